// ---- core/ms_tick_gen.sv ----
// one-cycle millisecond enable pulse from a cycle divider
`timescale 1ns/1ps
`include "scan_guard_defines.svh"
module ms_tick_gen #(
	parameter int unsigned MS_CYCLES = `MS_TICK_CYCLES
) (
	// clock and reset
	input  wire logic   core_clk,
	input  wire logic   rst_n,
	// timebase
	ms_tick_if.gen      tb
);
	logic [15:0] div_ff;
	logic        tick_ff;

	// clear realigns the divider so a new scan starts on a whole millisecond
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_ff  <= 16'h0000;
			tick_ff <= 1'b0;
		end else if (tb.clear) begin
			div_ff  <= 16'h0000;
			tick_ff <= 1'b0;
		end else if (div_ff == 16'(MS_CYCLES - 1)) begin
			div_ff  <= 16'h0000;
			tick_ff <= 1'b1;
		end else begin
			div_ff  <= div_ff + 16'h0001;
			tick_ff <= 1'b0;
		end
	end

	assign tb.tick = tick_ff;
endmodule

// ---- core/scan_cycle_timing_guard.sv ----
// scan cycle timing guard: minimum cycle padding, watch cycle and servicing overrun supervision
// Summary of operation
// - minimum cycle 1 to 32000 ms, 1 ms steps
// - minimum word binary ms; zero disables, reset zero
// - early scan waits out minimum before next scan
// - long scan restarts immediately, no padding added
// - scan over watch limit flags and halts
// - watch bit 15 picks default 1 s or field
// - watch field counts 10 ms steps, up to 32767
// - parallel mode watches program execution time only
// - servicing cycle over 2.0 s flags and halts
`timescale 1ns/1ps
`include "scan_guard_defines.svh"
module scan_cycle_timing_guard
	import scan_guard_pkg::*;
#(
	parameter int unsigned MS_CYCLES = `MS_TICK_CYCLES
) (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// wishbone classic slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [11:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// execution engine
	input  wire logic        exec_done,
	input  wire logic        scan_done,
	input  wire logic        periph_start,
	input  wire logic        periph_end,
	output logic             scan_go,
	output logic             halted,
	// interrupt
	output logic             irq
);
	guard_state_t          state_ff;
	guard_state_t          nxt_state;
	logic [15:0]           min_cycle_ff;
	logic [15:0]           watch_cycle_ff;
	logic [`EVT_W-1:0]     status_ff;
	logic [`EVT_W-1:0]     mask_ff;
	logic [1:0]            control_ff;
	logic [`MS_W-1:0]      scan_ms_ff;
	logic [`MS_W-1:0]      svc_ms_ff;
	logic                  watching_ff;
	logic                  svc_busy_ff;
	logic                  scan_go_ff;
	logic                  ack_ff;
	logic [31:0]           rdata_ff;
	logic [`MS_W-1:0]      watch_lim;
	logic [`MS_W-1:0]      min_lim;
	logic                  start_scan;
	logic                  cyc_over_evt;
	logic                  svc_over_evt;
	logic                  scan_end_evt;
	logic [`EVT_W-1:0]     evt_set;
	logic                  wr_req;
	logic [9:0]            reg_idx;
	logic                  run_en;
	logic                  parallel_en;

	ms_tick_if tb ();

	ms_tick_gen #(
		.MS_CYCLES (MS_CYCLES)
	) u_tick (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.tb       (tb.gen)
	);

	// counters stick at full scale rather than wrap, so a hung scan cannot look short
	function automatic logic [`MS_W-1:0] sat_inc(input logic [`MS_W-1:0] v);
		sat_inc = (&v) ? v : v + `MS_W'(1);
	endfunction

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
	                                        input logic [3:0] sel);
		merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	assign run_en      = control_ff[`CTRL_RUN_BIT];
	assign parallel_en = control_ff[`CTRL_PARALLEL_BIT];
	assign reg_idx     = wb_adr_i[11:2];
	assign wr_req      = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;

	// limits in ms; a zero minimum never pads because the count is never below it
	assign min_lim   = `MS_W'(min_cycle_ff);
	assign watch_lim = watch_cycle_ff[`WATCH_USER_BIT] ?
	                   `MS_W'(watch_cycle_ff[`WATCH_FIELD_MSB:0]) * `WATCH_STEP_MS :
	                   `WATCH_DEFAULT_MS;

	// overrun and scan events
	assign cyc_over_evt = (state_ff == ST_SCAN) && watching_ff && (scan_ms_ff > watch_lim);
	assign svc_over_evt = svc_busy_ff && (svc_ms_ff > `SERVICE_LIMIT_MS);
	assign scan_end_evt = (state_ff == ST_SCAN) && scan_done;
	assign evt_set      = {scan_end_evt, svc_over_evt, cyc_over_evt};

	// scan sequencing
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (run_en) begin
					nxt_state = ST_SCAN;
				end
			end
			ST_SCAN: begin
				if (!run_en) begin
					nxt_state = ST_IDLE;
				end else if (scan_done && (scan_ms_ff < min_lim)) begin
					nxt_state = ST_PAD;
				end
			end
			ST_PAD: begin
				if (!run_en) begin
					nxt_state = ST_IDLE;
				end else if (scan_ms_ff >= min_lim) begin
					nxt_state = ST_SCAN;
				end
			end
			ST_HALT: begin
				if (!run_en) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		// any overrun stops operation, whatever the sequence was doing
		if (cyc_over_evt || svc_over_evt) begin
			nxt_state = ST_HALT;
		end
	end

	// a scan starts on entry to SCAN, or back to back when a long scan ends
	assign start_scan = (nxt_state == ST_SCAN) && ((state_ff != ST_SCAN) || scan_done);
	assign tb.clear   = start_scan;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// start pulse to the engine
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_go_ff <= 1'b0;
		end else begin
			scan_go_ff <= start_scan;
		end
	end

	// per-scan millisecond counter, restarted by every scan start
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			scan_ms_ff <= '0;
		end else if (start_scan) begin
			scan_ms_ff <= '0;
		end else if (tb.tick) begin
			scan_ms_ff <= sat_inc(scan_ms_ff);
		end
	end

	// watch window: program execution only in parallel mode, whole scan otherwise
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			watching_ff <= 1'b0;
		end else if (start_scan) begin
			watching_ff <= 1'b1;
		end else if (parallel_en ? exec_done : scan_done) begin
			watching_ff <= 1'b0;
		end
	end

	// servicing cycle timer; tick is not realigned here, so it may read up to 1 ms high
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			svc_busy_ff <= 1'b0;
			svc_ms_ff   <= '0;
		end else if (periph_start) begin
			svc_busy_ff <= 1'b1;
			svc_ms_ff   <= '0;
		end else if (periph_end) begin
			svc_busy_ff <= 1'b0;
		end else if (svc_busy_ff && tb.tick) begin
			svc_ms_ff <= sat_inc(svc_ms_ff);
		end
	end

	// configuration registers with byte lanes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			min_cycle_ff   <= `MIN_CYCLE_RESET;
			watch_cycle_ff <= `WATCH_CYCLE_RESET;
			mask_ff        <= `MASK_RESET;
			control_ff     <= `CONTROL_RESET;
		end else if (wr_req) begin
			if (reg_idx == `MIN_CYCLE_IDX) begin
				min_cycle_ff <= merge16(min_cycle_ff, wb_dat_i, wb_sel_i);
			end
			if (reg_idx == `WATCH_CYCLE_IDX) begin
				watch_cycle_ff <= merge16(watch_cycle_ff, wb_dat_i, wb_sel_i);
			end
			if (reg_idx == `MASK_IDX && wb_sel_i[0]) begin
				mask_ff <= wb_dat_i[`EVT_W-1:0];
			end
			if (reg_idx == `CONTROL_IDX && wb_sel_i[0]) begin
				control_ff <= wb_dat_i[1:0];
			end
		end
	end

	// sticky status: write one clears, a same-cycle event wins over the clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_ff <= `STATUS_RESET;
		end else if (wr_req && reg_idx == `STATUS_IDX && wb_sel_i[0]) begin
			status_ff <= (status_ff & ~wb_dat_i[`EVT_W-1:0]) | evt_set;
		end else begin
			status_ff <= status_ff | evt_set;
		end
	end

	// bus answer one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ack_ff <= wb_cyc_i && wb_stb_i && !ack_ff;
			case (reg_idx)
				`MIN_CYCLE_IDX:    rdata_ff <= {16'h0000, min_cycle_ff};
				`WATCH_CYCLE_IDX:  rdata_ff <= {16'h0000, watch_cycle_ff};
				`STATUS_IDX:       rdata_ff <= {29'h0000000, status_ff};
				`MASK_IDX:         rdata_ff <= {29'h0000000, mask_ff};
				`CONTROL_IDX:      rdata_ff <= {30'h00000000, control_ff};
				`SCAN_TIME_IDX:    rdata_ff <= {12'h000, scan_ms_ff};
				`SERVICE_TIME_IDX: rdata_ff <= {12'h000, svc_ms_ff};
				default:           rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdata_ff;
	assign scan_go  = scan_go_ff;
	assign halted   = (state_ff == ST_HALT);
	assign irq      = |(status_ff & mask_ff);

	// checks
	property p_pad_needs_min;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == ST_PAD) |-> (min_cycle_ff != 16'h0000);
	endproperty
	a_pad_needs_min: assert property (p_pad_needs_min)
		else $error("padding with no minimum set");

	property p_pad_bounded;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == ST_PAD) |-> (scan_ms_ff <= min_lim);
	endproperty
	a_pad_bounded: assert property (p_pad_bounded)
		else $error("padding ran past the minimum");

	property p_pad_release;
		@(posedge core_clk) disable iff (!rst_n)
		(state_ff == ST_PAD && scan_ms_ff >= min_lim && run_en && !svc_over_evt) |-> ##1 scan_go_ff;
	endproperty
	a_pad_release: assert property (p_pad_release)
		else $error("no scan start after minimum elapsed");

	property p_long_no_pad;
		@(posedge core_clk) disable iff (!rst_n)
		(scan_end_evt && scan_ms_ff >= min_lim && run_en && !cyc_over_evt && !svc_over_evt)
			|=> scan_go_ff && (state_ff == ST_SCAN);
	endproperty
	a_long_no_pad: assert property (p_long_no_pad)
		else $error("long scan was padded");

	property p_cycle_halt;
		@(posedge core_clk) disable iff (!rst_n)
		cyc_over_evt |=> halted && status_ff[`STAT_CYCLE_BIT] && !scan_go_ff;
	endproperty
	a_cycle_halt: assert property (p_cycle_halt)
		else $error("cycle overrun did not flag and halt");

	property p_default_watch;
		@(posedge core_clk) disable iff (!rst_n)
		!watch_cycle_ff[`WATCH_USER_BIT] |-> (watch_lim == 20'd1000);
	endproperty
	a_default_watch: assert property (p_default_watch)
		else $error("default watch limit not one second");

	property p_user_watch;
		@(posedge core_clk) disable iff (!rst_n)
		watch_cycle_ff[`WATCH_USER_BIT] |-> (watch_lim == 20'(watch_cycle_ff[14:0]) * 20'd10);
	endproperty
	a_user_watch: assert property (p_user_watch)
		else $error("user watch limit not in 10 ms steps");

	property p_parallel_exec;
		@(posedge core_clk) disable iff (!rst_n)
		(parallel_en && exec_done && !start_scan) |=> !watching_ff ##1 !cyc_over_evt;
	endproperty
	a_parallel_exec: assert property (p_parallel_exec)
		else $error("watch kept running after program execution");

	property p_service_halt;
		@(posedge core_clk) disable iff (!rst_n)
		(svc_busy_ff && svc_ms_ff == 20'd2001) |=> halted && status_ff[`STAT_SERVICE_BIT] && irq == mask_ff[1];
	endproperty
	a_service_halt: assert property (p_service_halt)
		else $error("servicing overrun did not flag and halt");

	property p_scan_restart;
		@(posedge core_clk) disable iff (!rst_n)
		start_scan |=> (scan_ms_ff == 20'd0) && scan_go_ff;
	endproperty
	a_scan_restart: assert property (p_scan_restart)
		else $error("scan counter not restarted");

	property p_halt_no_go;
		@(posedge core_clk) disable iff (!rst_n)
		halted |-> !scan_go_ff;
	endproperty
	a_halt_no_go: assert property (p_halt_no_go)
		else $error("scan started while halted");

	property p_min_write;
		@(posedge core_clk) disable iff (!rst_n)
		(wr_req && reg_idx == `MIN_CYCLE_IDX && wb_sel_i[1:0] == 2'b11) |=> (min_cycle_ff == $past(wb_dat_i[15:0]));
	endproperty
	a_min_write: assert property (p_min_write)
		else $error("minimum cycle write did not land");
endmodule

// ---- include/ms_tick_if.sv ----
// millisecond timebase carrier between the tick generator and the guard
`timescale 1ns/1ps
interface ms_tick_if;
	logic tick;
	logic clear;
	modport gen (input clear, output tick);
	modport use_tick (output clear, input tick);
endinterface

// ---- include/scan_guard_defines.svh ----
// register map, field positions, reset values and timing counts of the scan timing guard
`ifndef SCAN_GUARD_DEFINES_SVH
`define SCAN_GUARD_DEFINES_SVH

// printed register indices; byte address is four times the index
`define MIN_CYCLE_IDX      10'h0D0
`define WATCH_CYCLE_IDX    10'h0D1
`define STATUS_IDX         10'h0D2
`define MASK_IDX           10'h0D3
`define CONTROL_IDX        10'h0D4
`define SCAN_TIME_IDX      10'h0D5
`define SERVICE_TIME_IDX   10'h0D6

// reset values
`define MIN_CYCLE_RESET    16'h0000
`define WATCH_CYCLE_RESET  16'h0001
`define STATUS_RESET       3'h0
`define MASK_RESET         3'h0
`define CONTROL_RESET      2'h0

// field positions
`define WATCH_USER_BIT     15
`define WATCH_FIELD_MSB    14
`define STAT_CYCLE_BIT     0
`define STAT_SERVICE_BIT   1
`define STAT_SCAN_END_BIT  2
`define CTRL_RUN_BIT       0
`define CTRL_PARALLEL_BIT  1

// widths
`define MS_W               20
`define EVT_W              3

// timing: one millisecond tick at a 25 ns clock
`define CORE_CLK_PERIOD_NS 25
`define MS_TICK_TIME_NS    1000000
`define MS_TICK_CYCLES     (`MS_TICK_TIME_NS / `CORE_CLK_PERIOD_NS)
`define WATCH_DEFAULT_S    1
`define WATCH_DEFAULT_MS   20'(`WATCH_DEFAULT_S * 1000)
`define WATCH_STEP_MS      20'd10
`define SERVICE_LIMIT_MS   20'd2000

`endif

// ---- include/scan_guard_pkg.sv ----
// types shared by the scan timing guard modules
package scan_guard_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SCAN,
		ST_PAD,
		ST_HALT
	} guard_state_t;
endpackage

// ---- verification/testbench.sv ----
// self-checking bench for the scan cycle timing guard: registers, padding, watch and servicing limits
`timescale 1ns/1ps
`include "scan_guard_defines.svh"
module testbench;
	// clock, reset and block ports
	logic        core_clk = 1'b0;
	logic        rst_n;
	logic        wb_cyc_i, wb_stb_i, wb_we_i;
	logic [11:0] wb_adr_i;
	logic [3:0]  wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic        wb_ack_o;
	logic        exec_done, scan_done, periph_start, periph_end;
	logic        scan_go, halted, irq;
	int          error_cnt = 0;
	int          tests_run = 0;
	int          n, m;

	// short millisecond so the 2 s servicing limit fits the run
	scan_cycle_timing_guard #(.MS_CYCLES(4)) i_scan_cycle_timing_guard (
		.core_clk(core_clk), .rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.exec_done(exec_done), .scan_done(scan_done), .periph_start(periph_start),
		.periph_end(periph_end), .scan_go(scan_go), .halted(halted), .irq(irq)
	);

	always #12.5 core_clk = ~core_clk;

	task automatic test_done();
		if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// exact value compare; case equality so an unknown never matches
	task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	// cycle count compare against a window
	task automatic chk_range(input string what, input int lo, input int hi, input int got);
		tests_run++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	// one classic wishbone cycle; request held until ack is sampled
	task automatic wb_xfer(input logic [9:0] idx, input logic we, input logic [15:0] d, output logic [31:0] q);
		int k;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_adr_i <= {idx, 2'b00};
		wb_sel_i <= 4'hF;
		wb_dat_i <= {16'h0000, d};
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 100);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (k >= 100) chk_val("wb ack", 32'h1, 32'h0);
	endtask

	task automatic wr(input logic [9:0] idx, input logic [15:0] d);
		logic [31:0] q;
		wb_xfer(idx, 1'b1, d, q);
	endtask

	task automatic rd_chk(input string what, input logic [9:0] idx, input logic [31:0] exp);
		wb_xfer(idx, 1'b0, 16'h0000, rd);
		chk_val(what, exp, rd);
	endtask

	// bounded waits for the engine outputs; k counts edges from the call
	task automatic wait_go(output int k);
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (scan_go !== 1'b1 && k < 200);
	endtask

	task automatic wait_halt(input int lim, output int k);
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (halted !== 1'b1 && k < lim);
	endtask

	task automatic pulse_done();
		@(posedge core_clk);
		scan_done <= 1'b1;
		@(posedge core_clk);
		scan_done <= 1'b0;
	endtask

	// reset values and the unmapped hole
	task automatic t_reset();
		rd_chk("min reset", `MIN_CYCLE_IDX, 32'h0000_0000);
		rd_chk("watch reset", `WATCH_CYCLE_IDX, 32'h0000_0001);
		rd_chk("status reset", `STATUS_IDX, 32'h0000_0000);
		rd_chk("mask reset", `MASK_IDX, 32'h0000_0000);
		rd_chk("control reset", `CONTROL_IDX, 32'h0000_0000);
		wr(10'h0E0, 16'hFFFF);
		rd_chk("unmapped", 10'h0E0, 32'h0000_0000);
		wr(`MIN_CYCLE_IDX, 16'h7D00);
		rd_chk("min top", `MIN_CYCLE_IDX, 32'h0000_7D00);
	endtask

	// no minimum: next scan starts the cycle after scan end
	task automatic t_no_pad();
		wr(`MIN_CYCLE_IDX, 16'h0000);
		wr(`CONTROL_IDX, 16'h0001);
		wait_go(n);
		pulse_done();
		wait_go(n);
		chk_range("back to back go", 1, 1, n);
	endtask

	// 3 ms minimum pads an early scan to a 14-cycle period
	task automatic t_pad();
		wr(`MIN_CYCLE_IDX, 16'h0003);
		// end the scan still running from the last scenario, then time a fresh one
		pulse_done();
		wait_go(n);
		pulse_done();
		wait_go(n);
		chk_range("padded period", 12, 14, n + 2);
		wr(`CONTROL_IDX, 16'h0000);
		wr(`MIN_CYCLE_IDX, 16'h0000);
	endtask

	// user watch of 10 ms overruns, interrupt masked in then out, cleared by one
	task automatic t_watch_user();
		wr(`STATUS_IDX, 16'h0007);
		wr(`MASK_IDX, 16'h0001);
		wr(`WATCH_CYCLE_IDX, 16'h8001);
		wr(`CONTROL_IDX, 16'h0001);
		wait_go(n);
		// program end must not stop the watch outside parallel mode
		@(posedge core_clk);
		exec_done <= 1'b1;
		@(posedge core_clk);
		exec_done <= 1'b0;
		wait_halt(200, n);
		chk_range("user watch halt", 41, 50, n);
		wb_xfer(`SCAN_TIME_IDX, 1'b0, 16'h0000, rd);
		chk_range("scan count", 11, 13, rd);
		rd_chk("cycle overrun", `STATUS_IDX, 32'h0000_0001);
		chk_val("irq on", 32'h1, {31'h0, irq});
		wr(`MASK_IDX, 16'h0000);
		chk_val("irq masked", 32'h0, {31'h0, irq});
		wr(`STATUS_IDX, 16'h0007);
		rd_chk("status cleared", `STATUS_IDX, 32'h0000_0000);
		wr(`CONTROL_IDX, 16'h0000);
		// the state moves at the ack edge, so look one edge later
		@(posedge core_clk);
		chk_val("halt left", 32'h0, {31'h0, halted});
	endtask

	// bit 15 clear ignores the field and applies one second
	task automatic t_watch_default();
		wr(`WATCH_CYCLE_IDX, 16'h0001);
		wr(`CONTROL_IDX, 16'h0001);
		wait_go(n);
		wait_halt(4200, n);
		chk_range("default watch halt", 4001, 4010, n);
		wr(`CONTROL_IDX, 16'h0000);
		wr(`STATUS_IDX, 16'h0007);
	endtask

	// parallel mode stops the watch at program end; servicing overrun after 2 s
	task automatic t_parallel();
		wr(`WATCH_CYCLE_IDX, 16'h8001);
		wr(`CONTROL_IDX, 16'h0003);
		wait_go(n);
		// a short servicing cycle of 20 clocks runs alongside and must stop its timer at the end
		@(posedge core_clk);
		exec_done <= 1'b1;
		periph_start <= 1'b1;
		@(posedge core_clk);
		exec_done <= 1'b0;
		periph_start <= 1'b0;
		repeat (20) @(posedge core_clk);
		periph_end <= 1'b1;
		@(posedge core_clk);
		periph_end <= 1'b0;
		repeat (100) @(posedge core_clk);
		chk_val("parallel no halt", 32'h0, {31'h0, halted});
		wb_xfer(`SERVICE_TIME_IDX, 1'b0, 16'h0000, rd);
		chk_range("short servicing count", 4, 6, rd);
		@(posedge core_clk);
		periph_start <= 1'b1;
		@(posedge core_clk);
		periph_start <= 1'b0;
		wait_halt(8200, m);
		chk_range("servicing halt", 7990, 8020, m);
		wb_xfer(`STATUS_IDX, 1'b0, 16'h0000, rd);
		chk_val("servicing flag", 32'h2, rd & 32'h3);
		wb_xfer(`SERVICE_TIME_IDX, 1'b0, 16'h0000, rd);
		chk_range("servicing count", 2001, 2003, rd);
	endtask

	// watchdog sized well above the sum of the scenarios
	initial begin
		repeat (40000) @(posedge core_clk);
		error_cnt++;
		test_done();
	end

	initial begin
		rst_n = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 12'h000;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0000_0000;
		{exec_done, scan_done, periph_start, periph_end} = 4'h0;
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_no_pad();
		t_pad();
		t_watch_user();
		t_watch_default();
		t_parallel();
		test_done();
	end
endmodule
